// ===== include/rtcpit_pkg.sv
// Constants, register map and carrier types of the counter/periodic timer block.
// Assumes an APB master on the bus clock and a slow counter clock arriving on a pin.
//
// What this block does
// - Counter and periodic timer advance only on counter clock edges; writes arrive late.
// - Sync status bits 3..0 show compare, period, count, control writes in flight.
// - Periodic status bit 0 shows a periodic control write still in flight.
// - A prescaler write reaches the counter two counter clock edges later.
// - Control bits 6:3 divide the counter clock by two to that power; value 15 gives one tick per 32768 edges.
// - Control bit 7 set keeps the counter running in standby sleep.
// - Control bit 0 enables the counter.
// - Interrupt enable bit 1 gates the compare match request.
// - Interrupt enable bit 0 gates the overflow request.
// - Compare flag sets when the count equals the compare value.
// - Overflow flag sets when the count passes the period and wraps to zero.
// - Writing one clears a flag; writing zero leaves it.
// - Counter debug-run set keeps the counter running during a debug halt.
// - Counter debug-run clear stops the counter and drops events during a halt.
// - Periodic debug-run set keeps the periodic timer running during a halt.
// - Periodic debug-run clear forces the periodic output low during a halt.
// - A halt that cut a high output yields one extra rising edge and flag.
// - Periodic field n gives 2^(n+1) cycle periods; 0 is off, 0xF reserved.
// - Request stays high while flag and enable are both set.
// - The periodic output toggles each half period; rising edges set its flag.

package rtcpit_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_SYNC_STATUS = 6'h01;
    localparam logic [5:0] IDX_IRQ_EN = 6'h02;
    localparam logic [5:0] IDX_IRQ_FLAGS = 6'h03;
    localparam logic [5:0] IDX_WIDE_BUF = 6'h04;
    localparam logic [5:0] IDX_DEBUG = 6'h05;
    localparam logic [5:0] IDX_CLK_SEL = 6'h07;
    localparam logic [5:0] IDX_COUNT = 6'h08;
    localparam logic [5:0] IDX_PERIOD = 6'h0A;
    localparam logic [5:0] IDX_COMPARE = 6'h0C;
    localparam logic [5:0] IDX_PIT_CTRL = 6'h10;
    localparam logic [5:0] IDX_PIT_STATUS = 6'h11;
    localparam logic [5:0] IDX_PIT_IRQ_EN = 6'h12;
    localparam logic [5:0] IDX_PIT_IRQ_FLAG = 6'h13;
    localparam logic [5:0] IDX_PIT_DEBUG = 6'h15;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_PSC_LSB = 3;
    localparam int CTRL_STDBY_BIT = 7;
    localparam int PIT_EN_BIT = 0;
    localparam int PIT_PER_LSB = 3;
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_CMP_BIT = 1;

    // Busy group order; bits 3..0 land directly in the sync status register
    localparam int GRP_CTRL = 0;
    localparam int GRP_CNT = 1;
    localparam int GRP_PER = 2;
    localparam int GRP_CMP = 3;
    localparam int GRP_PIT = 4;
    localparam int NUM_GRP = 5;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [15:0] PER_RST = 16'hFFFF;
    localparam logic [1:0] SYNC_TICKS = 2'h2;
    localparam logic [3:0] PIT_FIELD_RESERVED = 4'hF;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } rtcpit_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } rtcpit_apb_rsp_t;

endpackage : rtcpit_pkg

// ===== rtl/rtcpit_core.sv
// Counter, periodic timer, their sync busy tracking and the APB register slave.
// Assumes counter_clk_in is a free slow clock from a pin; debug_halt and
// standby_sleep come from logic on clk.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps

module rtcpit_core (
    input wire logic clk,
    input wire logic reset,
    input wire rtcpit_pkg::rtcpit_apb_req_t apb_req,
    output rtcpit_pkg::rtcpit_apb_rsp_t apb_rsp,
    input wire logic counter_clk_in,
    input wire logic debug_halt,
    input wire logic standby_sleep,
    output logic counter_irq,
    output logic periodic_irq,
    output logic overflow_event,
    output logic compare_event,
    output logic periodic_wave
);
    import rtcpit_pkg::*;

    typedef struct packed {
        logic pin_a;
        logic pin_b;
        logic pin_prev;
        logic [7:0] ctrl_sh;
        logic [7:0] ctrl;
        logic [15:0] cnt_sh;
        logic [15:0] per_sh;
        logic [15:0] period_value;
        logic [15:0] cmp_sh;
        logic [15:0] cmp;
        logic [7:0] pit_sh;
        logic [7:0] periodic_tick_timer;
        logic [NUM_GRP-1:0][1:0] sync_cnt;
        logic [NUM_GRP-1:0] busy;
        logic [1:0] irq_en;
        logic [1:0] flags;
        logic [7:0] wide_buf;
        logic run_halt;
        logic [1:0] clk_sel;
        logic pit_irq_en;
        logic pit_flag;
        logic pit_run_halt;
        logic [14:0] psc;
        logic [15:0] cnt;
        logic pit_out;
        logic ovf_ev;
        logic cmp_ev;
        logic cnt_irq;
        logic pit_irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rtcpit_state_t;

    rtcpit_state_t s_r;
    rtcpit_state_t s_nxt;

    logic cclk_edge;
    logic cnt_run;
    logic pit_run;
    logic cnt_tick;
    logic [15:0] psc_mask;
    logic [15:0] cnt_step;
    logic [3:0] psc_sel;
    logic [3:0] pit_sel;
    logic pit_level;
    logic acc;
    logic wr;
    logic [5:0] idx;
    logic [31:0] rd;
    logic rd_ok;

    always_comb begin
        s_nxt = s_r;
        // --------------------------------------------------------------
        // Counter clock pin: two flops, then edge detect on the second
        // --------------------------------------------------------------
        s_nxt.pin_a = counter_clk_in;
        s_nxt.pin_b = s_r.pin_a;
        s_nxt.pin_prev = s_r.pin_b;
        cclk_edge = s_r.pin_b & ~s_r.pin_prev;

        // --------------------------------------------------------------
        // Counting, only on counter clock edges
        // --------------------------------------------------------------
        cnt_run = s_r.ctrl[CTRL_EN_BIT]
            & ~(debug_halt & ~s_r.run_halt)
            & ~(standby_sleep & ~s_r.ctrl[CTRL_STDBY_BIT]);
        pit_run = s_r.periodic_tick_timer[PIT_EN_BIT] & ~(debug_halt & ~s_r.pit_run_halt);
        psc_sel = s_r.ctrl[CTRL_PSC_LSB +: 4];
        psc_mask = (16'h0001 << psc_sel) - 16'h0001;
        cnt_tick = cclk_edge & cnt_run & (({1'b0, s_r.psc} & psc_mask) == psc_mask);
        s_nxt.ovf_ev = 1'b0;
        s_nxt.cmp_ev = 1'b0;
        cnt_step = s_r.cnt;
        if (cclk_edge & (cnt_run | pit_run)) begin
            s_nxt.psc = s_r.psc + 15'h0001;
        end else if (~s_r.ctrl[CTRL_EN_BIT] & ~s_r.periodic_tick_timer[PIT_EN_BIT]) begin
            s_nxt.psc = '0;
        end
        if (cnt_tick) begin
            if (s_r.cnt == s_r.period_value) begin
                cnt_step = 16'h0000;
                s_nxt.ovf_ev = 1'b1;
                s_nxt.flags[FLAG_OVF_BIT] = 1'b1;
            end else begin
                cnt_step = s_r.cnt + 16'h0001;
            end
            s_nxt.cnt = cnt_step;
            if (cnt_step == s_r.cmp) begin
                s_nxt.cmp_ev = 1'b1;
                s_nxt.flags[FLAG_CMP_BIT] = 1'b1;
            end
        end

        // --------------------------------------------------------------
        // Periodic timer: output follows one prescaler bit
        // --------------------------------------------------------------
        pit_sel = s_r.periodic_tick_timer[PIT_PER_LSB +: 4];
        pit_level = 1'b0;
        if (pit_sel != 4'h0 && pit_sel != PIT_FIELD_RESERVED) begin
            pit_level = s_r.psc[pit_sel];
        end
        s_nxt.pit_out = pit_level & pit_run;
        // Forcing low in a halt makes the resume edge visible here
        if (s_nxt.pit_out & ~s_r.pit_out) begin
            s_nxt.pit_flag = 1'b1;
        end

        // --------------------------------------------------------------
        // Sync busy: shadow moves to the active copy on the second edge
        // --------------------------------------------------------------
        if (cclk_edge) begin
            for (int i = 0; i < NUM_GRP; i++) begin
                if (s_r.busy[i]) begin
                    if (s_r.sync_cnt[i] == 2'h1) begin
                        s_nxt.busy[i] = 1'b0;
                        s_nxt.sync_cnt[i] = 2'h0;
                        case (i)
                            GRP_CTRL: s_nxt.ctrl = s_r.ctrl_sh;
                            GRP_CNT: s_nxt.cnt = s_r.cnt_sh;
                            GRP_PER: s_nxt.period_value = s_r.per_sh;
                            GRP_CMP: s_nxt.cmp = s_r.cmp_sh;
                            default: s_nxt.periodic_tick_timer = s_r.pit_sh;
                        endcase
                    end else begin
                        s_nxt.sync_cnt[i] = s_r.sync_cnt[i] - 2'h1;
                    end
                end
            end
        end

        // --------------------------------------------------------------
        // APB slave: pready one cycle into the access phase
        // --------------------------------------------------------------
        idx = apb_req.paddr[7:2];
        acc = apb_req.psel & apb_req.penable;
        wr = acc & s_r.pready & apb_req.pwrite;
        rd = 32'h0000_0000;
        rd_ok = 1'b1;
        case (idx)
            IDX_CTRL: rd[7:0] = s_r.ctrl_sh;
            IDX_SYNC_STATUS: rd[3:0] = s_r.busy[3:0];
            IDX_IRQ_EN: rd[1:0] = s_r.irq_en;
            IDX_IRQ_FLAGS: rd[1:0] = s_r.flags;
            IDX_WIDE_BUF: rd[7:0] = s_r.wide_buf;
            IDX_DEBUG: rd[0] = s_r.run_halt;
            IDX_CLK_SEL: rd[1:0] = s_r.clk_sel;
            IDX_COUNT: rd[15:0] = s_r.cnt;
            IDX_PERIOD: rd[15:0] = s_r.per_sh;
            IDX_COMPARE: rd[15:0] = s_r.cmp_sh;
            IDX_PIT_CTRL: rd[7:0] = s_r.pit_sh;
            IDX_PIT_STATUS: rd[0] = s_r.busy[GRP_PIT];
            IDX_PIT_IRQ_EN: rd[0] = s_r.pit_irq_en;
            IDX_PIT_IRQ_FLAG: rd[0] = s_r.pit_flag;
            IDX_PIT_DEBUG: rd[0] = s_r.pit_run_halt;
            default: rd_ok = 1'b0;
        endcase
        s_nxt.pready = acc & ~s_r.pready;
        s_nxt.pslverr = acc & ~s_r.pready & ~rd_ok;
        s_nxt.prdata = (acc & ~s_r.pready & ~apb_req.pwrite) ? rd : 32'h0000_0000;

        if (wr) begin
            case (idx)
                IDX_CTRL: begin
                    s_nxt.ctrl_sh = apb_req.pwdata[7:0] & 8'hF9;
                    s_nxt.busy[GRP_CTRL] = 1'b1;
                    s_nxt.sync_cnt[GRP_CTRL] = SYNC_TICKS;
                end
                IDX_IRQ_EN: s_nxt.irq_en = apb_req.pwdata[1:0];
                IDX_IRQ_FLAGS: begin
                    // A flag raised in this same cycle survives the clear
                    s_nxt.flags = s_nxt.flags & ~(apb_req.pwdata[1:0] & ~(s_nxt.flags
                        & ~s_r.flags));
                end
                IDX_WIDE_BUF: s_nxt.wide_buf = apb_req.pwdata[7:0];
                IDX_DEBUG: s_nxt.run_halt = apb_req.pwdata[0];
                IDX_CLK_SEL: s_nxt.clk_sel = apb_req.pwdata[1:0];
                IDX_COUNT: begin
                    s_nxt.cnt_sh = apb_req.pwdata[15:0];
                    s_nxt.busy[GRP_CNT] = 1'b1;
                    s_nxt.sync_cnt[GRP_CNT] = SYNC_TICKS;
                end
                IDX_PERIOD: begin
                    s_nxt.per_sh = apb_req.pwdata[15:0];
                    s_nxt.busy[GRP_PER] = 1'b1;
                    s_nxt.sync_cnt[GRP_PER] = SYNC_TICKS;
                end
                IDX_COMPARE: begin
                    s_nxt.cmp_sh = apb_req.pwdata[15:0];
                    s_nxt.busy[GRP_CMP] = 1'b1;
                    s_nxt.sync_cnt[GRP_CMP] = SYNC_TICKS;
                end
                IDX_PIT_CTRL: begin
                    s_nxt.pit_sh = apb_req.pwdata[7:0] & 8'h79;
                    s_nxt.busy[GRP_PIT] = 1'b1;
                    s_nxt.sync_cnt[GRP_PIT] = SYNC_TICKS;
                end
                IDX_PIT_IRQ_EN: s_nxt.pit_irq_en = apb_req.pwdata[0];
                IDX_PIT_IRQ_FLAG: begin
                    if (apb_req.pwdata[0] & ~(s_nxt.pit_flag & ~s_r.pit_flag)) begin
                        s_nxt.pit_flag = 1'b0;
                    end
                end
                IDX_PIT_DEBUG: s_nxt.pit_run_halt = apb_req.pwdata[0];
                default: ;
            endcase
        end

        // --------------------------------------------------------------
        // Requests follow flag and enable
        // --------------------------------------------------------------
        s_nxt.cnt_irq = |(s_nxt.flags & s_nxt.irq_en);
        s_nxt.pit_irq = s_nxt.pit_flag & s_nxt.pit_irq_en;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
            s_r.period_value <= PER_RST;
            s_r.per_sh <= PER_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign apb_rsp.pready = s_r.pready;
    assign apb_rsp.pslverr = s_r.pslverr;
    assign apb_rsp.prdata = s_r.prdata;
    assign counter_irq = s_r.cnt_irq;
    assign periodic_irq = s_r.pit_irq;
    assign overflow_event = s_r.ovf_ev;
    assign compare_event = s_r.cmp_ev;
    assign periodic_wave = s_r.pit_out;

endmodule : rtcpit_core

// ===== verification/rtcpit_monitor.sv
// Assertion checker for rtcpit_core, bound to every instance of the core.
// Assumes only the core's ports; enables and debug bits are shadowed from APB writes.
`timescale 1ns/100ps

module rtcpit_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire rtcpit_pkg::rtcpit_apb_req_t apb_req,
    input wire rtcpit_pkg::rtcpit_apb_rsp_t apb_rsp,
    input wire logic counter_clk_in,
    input wire logic debug_halt,
    input wire logic standby_sleep,
    input wire logic counter_irq,
    input wire logic periodic_irq,
    input wire logic overflow_event,
    input wire logic compare_event,
    input wire logic periodic_wave
);
    import rtcpit_pkg::*;

    // ------------------------------------------------------------------
    // Shadows of bus-side settings
    // ------------------------------------------------------------------
    logic done;
    logic [5:0] idx;
    logic [1:0] en_r;
    logic pen_r;
    logic dbg_r;
    logic pdbg_r;
    logic [2:0] age_r;
    logic [5:0] last_r;

    assign done = apb_req.psel && apb_req.penable && apb_rsp.pready;
    assign idx = apb_req.paddr[7:2];

    always_ff @(posedge clk) begin
        if (reset) begin
            en_r <= 2'h0;
            pen_r <= 1'h0;
            dbg_r <= 1'h0;
            pdbg_r <= 1'h0;
            age_r <= 3'h7;
            last_r <= 6'h3F;
        end else if (done && apb_req.pwrite) begin
            age_r <= 3'h0;
            last_r <= idx;
            if (idx == IDX_IRQ_EN) en_r <= apb_req.pwdata[1:0];
            if (idx == IDX_PIT_IRQ_EN) pen_r <= apb_req.pwdata[0];
            if (idx == IDX_DEBUG) dbg_r <= apb_req.pwdata[0];
            if (idx == IDX_PIT_DEBUG) pdbg_r <= apb_req.pwdata[0];
        end else if (age_r != 3'h7) begin
            age_r <= age_r + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_quiet;
        !overflow_event && !compare_event;
    endsequence
    sequence s_clear;
        (done && apb_req.pwrite && idx == IDX_IRQ_FLAGS && apb_req.pwdata[1:0] == 2'h3)
            ##1 s_quiet [*2];
    endsequence
    sequence s_rd(logic [5:0] reg_idx);
        done && !apb_req.pwrite && idx == reg_idx && age_r < 3'h4;
    endsequence

    AST_CTR_IRQ_GATED: assert property (en_r == 2'h0 [*2] |-> !counter_irq)
        else $error("counter request high with both sources disabled");
    AST_PIT_IRQ_GATED: assert property (!pen_r [*2] |-> !periodic_irq)
        else $error("periodic request high while disabled");
    AST_W1C_CLEARS: assert property (s_clear |-> !counter_irq)
        else $error("counter request survived a clear of both flags");
    AST_OVF_RAISES: assert property (overflow_event && en_r[0] |-> ##[0:2] counter_irq)
        else $error("overflow did not raise the counter request");
    AST_CMP_RAISES: assert property (compare_event && en_r[1] |-> ##[0:2] counter_irq)
        else $error("compare match did not raise the counter request");
    AST_SYNC_BUSY: assert property (s_rd(IDX_SYNC_STATUS) && last_r == IDX_CTRL |->
        apb_rsp.prdata[0])
        else $error("control busy not shown right after a control write");
    AST_PIT_BUSY: assert property (s_rd(IDX_PIT_STATUS) && last_r == IDX_PIT_CTRL |->
        apb_rsp.prdata[0])
        else $error("periodic busy not shown right after a periodic write");
    AST_WAVE_HALT: assert property ((debug_halt && !pdbg_r) [*3] |-> !periodic_wave)
        else $error("periodic output high during a halt");
    AST_EVT_HALT: assert property ((debug_halt && !dbg_r) [*5] |-> s_quiet)
        else $error("counter event during a halt");
    AST_WAVE_FLAG: assert property ($rose(periodic_wave) && pen_r |->
        ##[1:2] (periodic_irq || !pen_r))
        else $error("periodic rising edge did not raise its request");
endmodule : rtcpit_monitor

bind rtcpit_core rtcpit_monitor u_mon (.clk(clk), .reset(reset), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .counter_clk_in(counter_clk_in), .debug_halt(debug_halt),
    .standby_sleep(standby_sleep), .counter_irq(counter_irq), .periodic_irq(periodic_irq),
    .overflow_event(overflow_event), .compare_event(compare_event),
    .periodic_wave(periodic_wave));

// ===== verification/testbench.sv
// Self-checking bench for rtcpit_core: APB master tasks and one task per scenario.
// Assumes the package constants; the counter clock runs free at 5 MHz.
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module testbench;
    import rtcpit_pkg::*;
    logic clk;
    logic reset;
    logic cnt_clk;
    logic halt;
    logic stdby;
    logic c_irq;
    logic p_irq;
    logic wave;
    rtcpit_apb_req_t req;
    rtcpit_apb_rsp_t rsp;
    logic [31:0] rdata;
    int n_mismatch = 0;
    int comparisons = 0;

    rtcpit_core uut (.clk(clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
        .counter_clk_in(cnt_clk), .debug_halt(halt), .standby_sleep(stdby),
        .counter_irq(c_irq), .periodic_irq(p_irq), .overflow_event(), .compare_event(),
        .periodic_wave(wave));

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    // Odd offset keeps counter clock edges away from bus clock edges
    initial begin
        cnt_clk = 1'h0;
        #37;
        forever #100 cnt_clk = ~cnt_clk;
    end

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req.psel <= 1'h1;
        req.pwrite <= w;
        req.paddr <= {idx, 2'h0};
        req.pwdata <= d;
        @(posedge clk);
        req.penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'h1 && n < 20);
        if (n >= 20) n_mismatch++;
        rdata = rsp.prdata;
        req.psel <= 1'h0;
        req.penable <= 1'h0;
    endtask : apb

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        apb(1'h1, idx, d);
    endtask : wr

    task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
        apb(1'h0, idx, 32'h0);
        `CHK(rdata, exp)
    endtask : rd_chk

    // Software must not write again until every busy bit has dropped
    task automatic settle;
        logic [31:0] s;
        for (int n = 0; n < 100; n++) begin
            apb(1'h0, IDX_SYNC_STATUS, 32'h0);
            s = rdata;
            apb(1'h0, IDX_PIT_STATUS, 32'h0);
            if ((s[3:0] | rdata[3:0]) === 4'h0) break;
        end
    endtask : settle

    task automatic cnt_moves(input logic exp);
        logic [31:0] c0;
        repeat (10) @(posedge clk);
        apb(1'h0, IDX_COUNT, 32'h0);
        c0 = rdata;
        repeat (60) @(posedge clk);
        apb(1'h0, IDX_COUNT, 32'h0);
        `CHK(rdata !== c0, exp)
    endtask : cnt_moves

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        rd_chk(IDX_CTRL, 32'h0);
        rd_chk(IDX_SYNC_STATUS, 32'h0);
        rd_chk(IDX_PERIOD, 32'hFFFF);
        rd_chk(IDX_IRQ_FLAGS, 32'h0);
        apb(1'h0, 6'h06, 32'h0);
        `CHK(rsp.pslverr, 1'h1)
        `CHK(rdata, 32'h0)
    endtask : t_regs

    task automatic t_run;
        wr(IDX_CTRL, 32'h01);
        rd_chk(IDX_SYNC_STATUS, 32'h1);
        settle;
        cnt_moves(1'h1);
        halt <= 1'h1;
        cnt_moves(1'h0);
        wr(IDX_DEBUG, 32'h1);
        cnt_moves(1'h1);
        halt <= 1'h0;
        stdby <= 1'h1;
        cnt_moves(1'h0);
        wr(IDX_CTRL, 32'h81);
        settle;
        cnt_moves(1'h1);
        stdby <= 1'h0;
        wr(IDX_CTRL, 32'h79);
        settle;
        cnt_moves(1'h0);
        wr(IDX_CTRL, 32'h0);
        settle;
    endtask : t_run

    task automatic t_flags;
        wr(IDX_PERIOD, 32'h3);
        wr(IDX_COMPARE, 32'h2);
        wr(IDX_COUNT, 32'h0);
        settle;
        wr(IDX_CTRL, 32'h01);
        settle;
        repeat (100) @(posedge clk);
        `CHK(c_irq, 1'h0)
        rd_chk(IDX_IRQ_FLAGS, 32'h3);
        wr(IDX_IRQ_EN, 32'h3);
        repeat (3) @(posedge clk);
        `CHK(c_irq, 1'h1)
        wr(IDX_CTRL, 32'h0);
        settle;
        wr(IDX_IRQ_FLAGS, 32'h0);
        rd_chk(IDX_IRQ_FLAGS, 32'h3);
        wr(IDX_IRQ_EN, 32'h1);
        wr(IDX_IRQ_FLAGS, 32'h1);
        rd_chk(IDX_IRQ_FLAGS, 32'h2);
        `CHK(c_irq, 1'h0)
        wr(IDX_IRQ_FLAGS, 32'h3);
        rd_chk(IDX_IRQ_FLAGS, 32'h0);
    endtask : t_flags

    task automatic t_pit;
        wr(IDX_PIT_IRQ_EN, 32'h1);
        wr(IDX_PIT_CTRL, 32'h09);
        rd_chk(IDX_PIT_STATUS, 32'h1);
        for (int n = 0; n < 400 && p_irq !== 1'h1; n++) @(posedge clk);
        `CHK(p_irq, 1'h1)
        rd_chk(IDX_PIT_IRQ_FLAG, 32'h1);
        halt <= 1'h1;
        repeat (8) @(posedge clk);
        `CHK(wave, 1'h0)
        halt <= 1'h0;
        wr(IDX_PIT_CTRL, 32'h79);
        settle;
        wr(IDX_PIT_IRQ_FLAG, 32'h1);
        repeat (100) @(posedge clk);
        rd_chk(IDX_PIT_IRQ_FLAG, 32'h0);
    endtask : t_pit

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test

    initial begin
        #400000;
        n_mismatch++;
        end_of_test;
    end

    initial begin
        req = '0;
        reset = 1'h1;
        halt = 1'h0;
        stdby = 1'h0;
        repeat (5) @(posedge clk);
        reset <= 1'h0;
        t_regs;
        t_run;
        t_flags;
        t_pit;
        end_of_test;
    end
endmodule : testbench
